/* src/rtv_regs.svh */
// register offsets, field positions and reset values of the time/alarm value block
`ifndef RTV_REGS_SVH
`define RTV_REGS_SVH

`define RTV_ADDR_W 12
`define RTV_CTRL_OFF 12'h000
`define RTV_TIME_OFF 12'h004
`define RTV_ALARM_OFF 12'h008
`define RTV_STAT_OFF 12'h00C

`define RTV_CTRL_WREN_BIT 0
`define RTV_CTRL_TPTR_LSB 4
`define RTV_CTRL_APTR_LSB 8
`define RTV_STAT_REJ_BIT 0
`define RTV_STAT_BAD_BIT 1

`define RTV_TPTR_WEEKDAY_DIGIT_HOURS 2'h1
`define RTV_APTR_MIN_SEC 2'h0
`define RTV_PTR_RST 2'h0

`define RTV_WEEKDAY_DIGIT_MAX 3'h6
`define RTV_HTEN_MAX 2'h2
`define RTV_ONES_MAX 4'h9
`define RTV_TENS6_MAX 3'h5

`endif

/* src/rtv_pkg.sv */
// types shared by the time/alarm value block
package rtv_pkg;

  typedef struct packed {
    logic wren;
    logic [1:0] tptr;
    logic [1:0] aptr;
    logic [2:0] weekday_digit;
    logic [1:0] hten;
    logic [3:0] hone;
    logic [2:0] mten;
    logic [3:0] mone;
    logic [2:0] sten;
    logic [3:0] sone;
    logic rej;
    logic bad;
    logic [31:0] rdata;
  } rtv_state_t;

endpackage

/* src/rtv_bcd_check.sv */
// range check of the packed bcd digits of a time or alarm value word
`timescale 1ns/10ps
`include "rtv_regs.svh"

module rtv_bcd_check
  import rtv_pkg::*;
(
  input wire logic [15:0] i_word,
  input wire logic i_alarm,
  output logic o_legal
);

  always_comb begin
    if (i_alarm) begin
      o_legal = (i_word[14:12] <= `RTV_TENS6_MAX) && (i_word[11:8] <= `RTV_ONES_MAX) &&
                (i_word[6:4] <= `RTV_TENS6_MAX) && (i_word[3:0] <= `RTV_ONES_MAX);
    end else begin
      o_legal = (i_word[10:8] <= `RTV_WEEKDAY_DIGIT_MAX) && (i_word[5:4] <= `RTV_HTEN_MAX) &&
                (i_word[3:0] <= `RTV_ONES_MAX);
    end
  end

endmodule

/* src/rtv_value_regs.sv */
// apb register block holding the weekday/hours and alarm minutes/seconds value words
//
// Contract
// - time pointer 01 selects weekday and hour digits in the time value register.
// - weekday is a 3-bit field in bits 10-8, values 0 to 6.
// - hour tens is a 2-bit bcd field in bits 5-4, values 0 to 2.
// - hour ones is a 4-bit bcd field in bits 3-0, values 0 to 9.
// - time register writes take effect only while the write enable bit is 1.
// - bits 15-11 and 7-6 of the weekday/hours word read as zero.
// - alarm pointer 00 selects alarm minute and second digits.
// - alarm minute tens is a 3-bit bcd field in bits 14-12, 0 to 5.
// - alarm minute ones is a 4-bit bcd field in bits 11-8, 0 to 9.
// - alarm second tens is a 3-bit bcd field in bits 6-4, 0 to 5.
// - alarm second ones is a 4-bit bcd field in bits 3-0, 0 to 9.
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/10ps
`include "rtv_regs.svh"

module rtv_value_regs
  import rtv_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [`RTV_ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr
);

  rtv_state_t state_reg;
  rtv_state_t state_next;

  logic wr_access;
  logic rd_setup;
  logic time_hit;
  logic alarm_hit;
  logic [15:0] time_merged;
  logic [15:0] alarm_merged;
  logic time_legal;
  logic alarm_legal;

  // weekday/hours word, unimplemented bits forced low
  function automatic logic [15:0] time_word(input rtv_state_t s);
    time_word = {5'h00, s.weekday_digit, 2'h0, s.hten, s.hone};
  endfunction

  function automatic logic [15:0] alarm_word(input rtv_state_t s);
    alarm_word = {1'h0, s.mten, s.mone, 1'h0, s.sten, s.sone};
  endfunction

  // byte lane merge of the low half word
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] strb);
    merge16 = {strb[1] ? wd[15:8] : old[15:8], strb[0] ? wd[7:0] : old[7:0]};
  endfunction

  function automatic logic mapped(input logic [`RTV_ADDR_W-1:0] a);
    mapped = (a == `RTV_CTRL_OFF) || (a == `RTV_TIME_OFF) || (a == `RTV_ALARM_OFF) || (a == `RTV_STAT_OFF);
  endfunction

  assign wr_access = i_psel && i_penable && i_pwrite;
  assign rd_setup = i_psel && !i_penable && !i_pwrite;
  assign time_hit = state_reg.tptr == `RTV_TPTR_WEEKDAY_DIGIT_HOURS;
  assign alarm_hit = state_reg.aptr == `RTV_APTR_MIN_SEC;
  assign time_merged = merge16(time_word(state_reg), i_pwdata, i_pstrb);
  assign alarm_merged = merge16(alarm_word(state_reg), i_pwdata, i_pstrb);

  rtv_bcd_check u_time_check (
    .i_word(time_merged),
    .i_alarm(1'b0),
    .o_legal(time_legal)
  );

  rtv_bcd_check u_alarm_check (
    .i_word(alarm_merged),
    .i_alarm(1'b1),
    .o_legal(alarm_legal)
  );

  always_comb begin
    state_next = state_reg;
    if (wr_access) begin
      if (i_paddr == `RTV_CTRL_OFF) begin
        if (i_pstrb[0]) begin
          state_next.wren = i_pwdata[`RTV_CTRL_WREN_BIT];
          state_next.tptr = i_pwdata[`RTV_CTRL_TPTR_LSB +: 2];
        end
        if (i_pstrb[1]) begin
          state_next.aptr = i_pwdata[`RTV_CTRL_APTR_LSB +: 2];
        end
      end else if (i_paddr == `RTV_TIME_OFF) begin
        if (!state_reg.wren) begin
          state_next.rej = 1'b1;
        end else if (time_hit && !time_legal) begin
          state_next.bad = 1'b1;
        end else if (time_hit) begin
          state_next.weekday_digit = time_merged[10:8];
          state_next.hten = time_merged[5:4];
          state_next.hone = time_merged[3:0];
        end
      end else if (i_paddr == `RTV_ALARM_OFF) begin
        if (alarm_hit && !alarm_legal) begin
          state_next.bad = 1'b1;
        end else if (alarm_hit) begin
          state_next.mten = alarm_merged[14:12];
          state_next.mone = alarm_merged[11:8];
          state_next.sten = alarm_merged[6:4];
          state_next.sone = alarm_merged[3:0];
        end
      end else if (i_paddr == `RTV_STAT_OFF) begin
        // write one to clear, this later clear would have won over the set above but cannot coincide
        if (i_pstrb[0] && i_pwdata[`RTV_STAT_REJ_BIT]) begin
          state_next.rej = 1'b0;
        end
        if (i_pstrb[0] && i_pwdata[`RTV_STAT_BAD_BIT]) begin
          state_next.bad = 1'b0;
        end
      end
    end
    if (rd_setup) begin
      if (i_paddr == `RTV_CTRL_OFF) begin
        state_next.rdata = '0;
        state_next.rdata[`RTV_CTRL_WREN_BIT] = state_reg.wren;
        state_next.rdata[`RTV_CTRL_TPTR_LSB +: 2] = state_reg.tptr;
        state_next.rdata[`RTV_CTRL_APTR_LSB +: 2] = state_reg.aptr;
      end else if (i_paddr == `RTV_TIME_OFF) begin
        state_next.rdata = time_hit ? {16'h0000, time_word(state_reg)} : 32'h00000000;
      end else if (i_paddr == `RTV_ALARM_OFF) begin
        state_next.rdata = alarm_hit ? {16'h0000, alarm_word(state_reg)} : 32'h00000000;
      end else if (i_paddr == `RTV_STAT_OFF) begin
        state_next.rdata = '0;
        state_next.rdata[`RTV_STAT_REJ_BIT] = state_reg.rej;
        state_next.rdata[`RTV_STAT_BAD_BIT] = state_reg.bad;
      end else begin
        state_next.rdata = 32'h00000000;
      end
    end
    if (i_rst) begin
      // value digits are deliberately left as they are
      state_next.wren = 1'b0;
      state_next.tptr = `RTV_PTR_RST;
      state_next.aptr = `RTV_PTR_RST;
      state_next.rej = 1'b0;
      state_next.bad = 1'b0;
      state_next.rdata = 32'h00000000;
    end
  end

  always_ff @(posedge i_clk) begin
    state_reg <= state_next;
  end

  assign o_prdata = state_reg.rdata;
  assign o_pready = i_psel && i_penable;
  assign o_pslverr = i_psel && i_penable && !mapped(i_paddr);

  // checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  logic time_wr;
  logic alarm_wr;
  logic ctrl_wr;
  logic stat_wr;
  logic bus_acc;
  logic time_rd;
  logic alarm_rd;
  assign time_wr = wr_access && (i_paddr == `RTV_TIME_OFF);
  assign alarm_wr = wr_access && (i_paddr == `RTV_ALARM_OFF);
  assign ctrl_wr = wr_access && (i_paddr == `RTV_CTRL_OFF);
  assign stat_wr = wr_access && (i_paddr == `RTV_STAT_OFF);
  assign bus_acc = i_psel && i_penable;
  assign time_rd = rd_setup && (i_paddr == `RTV_TIME_OFF);
  assign alarm_rd = rd_setup && (i_paddr == `RTV_ALARM_OFF);

  // bus handshake
  chk_ready_zero_wait: assert property (bus_acc |-> o_pready)
    else $error("ready missing in access phase");

  chk_ready_idle: assert property (!bus_acc |-> !o_pready)
    else $error("ready outside access phase");

  chk_err_unmapped: assert property (bus_acc && !mapped(i_paddr) |-> o_pslverr)
    else $error("unmapped access without error");

  chk_err_mapped: assert property (bus_acc && mapped(i_paddr) |-> !o_pslverr)
    else $error("mapped access flagged as error");

  chk_rdata_hold: assert property (!rd_setup |=> $stable(o_prdata))
    else $error("read data moved without a read setup");

  chk_unmapped_read: assert property (rd_setup && !mapped(i_paddr)
    |=> o_prdata == 32'h00000000)
    else $error("unmapped read not zero");

  // time value word
  chk_time_locked: assert property (time_wr && !state_reg.wren |=> $stable(time_word(state_reg)))
    else $error("time digits changed while write enable clear");

  chk_time_lock_flag: assert property (time_wr && !state_reg.wren |=> state_reg.rej)
    else $error("rejected time write not flagged");

  chk_time_lock_no_err: assert property (time_wr && !state_reg.wren |-> !o_pslverr)
    else $error("rejected time write raised bus error");

  chk_weekday_store: assert property (time_wr && state_reg.wren && time_hit && time_legal && i_pstrb[1]
    |=> state_reg.weekday_digit == $past(i_pwdata[10:8]))
    else $error("weekday not stored from bits 10-8");

  chk_hour_store: assert property (time_wr && state_reg.wren && time_hit && time_legal && i_pstrb[0]
    |=> state_reg.hten == $past(i_pwdata[5:4]) && state_reg.hone == $past(i_pwdata[3:0]))
    else $error("hour digits not stored from bits 5-0");

  chk_time_legal: assert property (time_wr && state_reg.wren && time_hit && time_legal
    |=> state_reg.weekday_digit <= `RTV_WEEKDAY_DIGIT_MAX && state_reg.hten <= `RTV_HTEN_MAX && state_reg.hone <= `RTV_ONES_MAX)
    else $error("illegal weekday/hour digit held");

  chk_time_bad_keep: assert property (time_wr && state_reg.wren && time_hit && !time_legal
    |=> $stable(time_word(state_reg)) && state_reg.bad)
    else $error("out of range time write not refused");

  chk_time_ptr_guard: assert property (time_wr && !time_hit
    |=> $stable(time_word(state_reg)))
    else $error("time write landed with other pointer");

  chk_time_read: assert property (time_rd && time_hit
    |=> o_prdata == {16'h0000, 5'h00, $past(state_reg.weekday_digit), 2'h0, $past(state_reg.hten), $past(state_reg.hone)})
    else $error("time value read mismatch");

  chk_time_ptr_miss: assert property (time_rd && !time_hit
    |=> o_prdata == 32'h00000000)
    else $error("time read with other pointer not zero");

  chk_time_zero_bits: assert property (time_rd
    |=> o_prdata[15:11] == 5'h00 && o_prdata[7:6] == 2'h0)
    else $error("unimplemented time bits read nonzero");

  chk_time_upper_zero: assert property (time_rd
    |=> o_prdata[31:16] == 16'h0000)
    else $error("upper half of time read nonzero");

  // alarm value word
  chk_alarm_store: assert property (alarm_wr && alarm_hit && alarm_legal && i_pstrb[1:0] == 2'h3
    |=> alarm_word(state_reg) == $past({1'h0, i_pwdata[14:8], 1'h0, i_pwdata[6:0]}))
    else $error("alarm digits not stored");

  chk_alarm_seconds: assert property (alarm_wr && alarm_hit && alarm_legal
    |=> state_reg.sten == $past(alarm_merged[6:4]) && state_reg.sone == $past(alarm_merged[3:0]))
    else $error("alarm second digits not stored");

  chk_alarm_legal: assert property (alarm_wr && alarm_hit && alarm_legal
    |=> state_reg.mten <= `RTV_TENS6_MAX && state_reg.mone <= `RTV_ONES_MAX &&
        state_reg.sten <= `RTV_TENS6_MAX && state_reg.sone <= `RTV_ONES_MAX)
    else $error("illegal alarm digit held");

  chk_alarm_bad_keep: assert property (alarm_wr && alarm_hit && !alarm_legal
    |=> $stable(alarm_word(state_reg)) && state_reg.bad)
    else $error("out of range alarm write not refused");

  chk_alarm_ptr_guard: assert property (alarm_wr && !alarm_hit
    |=> $stable(alarm_word(state_reg)))
    else $error("alarm write landed with other pointer");

  chk_alarm_read: assert property (alarm_rd && alarm_hit
    |=> o_prdata == {16'h0000, 1'h0, $past(state_reg.mten), $past(state_reg.mone), 1'h0,
                     $past(state_reg.sten), $past(state_reg.sone)})
    else $error("alarm value read mismatch");

  chk_alarm_ptr_miss: assert property (alarm_rd && !alarm_hit
    |=> o_prdata == 32'h00000000)
    else $error("alarm read with other pointer not zero");

  chk_alarm_zero_bits: assert property (alarm_rd
    |=> o_prdata[31:15] == 17'h00000 && o_prdata[7] == 1'b0)
    else $error("unimplemented alarm bits read nonzero");

  // control and status
  chk_ctrl_store: assert property (ctrl_wr && i_pstrb[0]
    |=> state_reg.wren == $past(i_pwdata[`RTV_CTRL_WREN_BIT]) &&
        state_reg.tptr == $past(i_pwdata[`RTV_CTRL_TPTR_LSB +: 2]))
    else $error("enable or time pointer not stored");

  chk_aptr_store: assert property (ctrl_wr && i_pstrb[1]
    |=> state_reg.aptr == $past(i_pwdata[`RTV_CTRL_APTR_LSB +: 2]))
    else $error("alarm pointer not stored");

  chk_ctrl_hold: assert property (!ctrl_wr
    |=> $stable(state_reg.wren) && $stable(state_reg.tptr) && $stable(state_reg.aptr))
    else $error("control bits moved without a control write");

  chk_ctrl_read: assert property (rd_setup && i_paddr == `RTV_CTRL_OFF
    |=> o_prdata == {22'h000000, $past(state_reg.aptr), 2'h0, $past(state_reg.tptr), 3'h0,
                     $past(state_reg.wren)})
    else $error("control read mismatch");

  chk_stat_read: assert property (rd_setup && i_paddr == `RTV_STAT_OFF
    |=> o_prdata == {30'h00000000, $past(state_reg.bad), $past(state_reg.rej)})
    else $error("status read mismatch");

  chk_rej_clear: assert property (stat_wr && i_pstrb[0] && i_pwdata[`RTV_STAT_REJ_BIT]
    |=> !state_reg.rej)
    else $error("rejected write flag not cleared");

  chk_bad_clear: assert property (stat_wr && i_pstrb[0] && i_pwdata[`RTV_STAT_BAD_BIT]
    |=> !state_reg.bad)
    else $error("range flag not cleared");

  chk_rej_sticky: assert property (state_reg.rej && !(stat_wr && i_pstrb[0] && i_pwdata[`RTV_STAT_REJ_BIT])
    |=> state_reg.rej)
    else $error("rejected write flag lost");

  chk_bad_sticky: assert property (state_reg.bad && !(stat_wr && i_pstrb[0] && i_pwdata[`RTV_STAT_BAD_BIT])
    |=> state_reg.bad)
    else $error("range flag lost");

  // reset must be seen, so the default disable is overridden
  chk_reset_state: assert property (disable iff (1'b0) i_rst
    |=> !state_reg.wren && state_reg.tptr == `RTV_PTR_RST && state_reg.aptr == `RTV_PTR_RST)
    else $error("control not reset");

  chk_reset_flags: assert property (disable iff (1'b0) i_rst
    |=> !state_reg.rej && !state_reg.bad && o_prdata == 32'h00000000)
    else $error("status or read data not reset");

  cov_time_write: cover property (time_wr && state_reg.wren && time_hit && time_legal);
  cov_time_rejected: cover property (time_wr && !state_reg.wren);
  cov_alarm_write: cover property (alarm_wr && alarm_hit && alarm_legal);
  cov_time_read: cover property (rd_setup && i_paddr == `RTV_TIME_OFF && time_hit);
  cov_bad_digit: cover property (time_wr && state_reg.wren && time_hit && !time_legal);

endmodule

/* verification/rtv_value_regs_test.sv */
// self-checking apb bench of the weekday/hours and alarm value registers
`timescale 1ns/10ps
`include "rtv_regs.svh"

module rtv_value_regs_test
  import rtv_pkg::*;
;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [`RTV_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] rd;
  logic err;
  logic [31:0] tword;
  logic [31:0] aword;
  logic [31:0] bad_t [3] = '{32'h0000_0700, 32'h0000_0030, 32'h0000_000A};
  logic [31:0] bad_a [4] = '{32'h0000_6000, 32'h0000_0A00, 32'h0000_0060, 32'h0000_000A};
  int err_count = 0;
  int total_checks = 0;

  always #10 clk = ~clk;

  rtv_value_regs rtv_value_regs_inst (.i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr));

  function automatic logic [31:0] tw(input logic [2:0] wd, input logic [1:0] ht, input logic [3:0] ho);
    return {21'h0, wd, 2'h0, ht, ho};
  endfunction

  function automatic logic [31:0] aw(input logic [2:0] mt, input logic [3:0] mo, input logic [2:0] st,
    input logic [3:0] so);
    return {17'h0, mt, mo, 1'h0, st, so};
  endfunction

  function automatic logic [31:0] cw(input logic en, input logic [1:0] tp, input logic [1:0] ap);
    return {22'h0, ap, 2'h0, tp, 3'h0, en};
  endfunction

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; read data and error taken at the ready edge
  task automatic apb(input logic wr, input logic [`RTV_ADDR_W-1:0] addr, input logic [31:0] data);
    int n = 0;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'h1) begin
      err_count++;
      $display("wrong value at %0t: no ready", $time);
      report_and_stop();
    end
  endtask

  initial begin
    void'($urandom(32'h5DF3));
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    apb(1'h0, `RTV_CTRL_OFF, 32'h0);
    check(rd, 32'h0);
    apb(1'h1, `RTV_CTRL_OFF, cw(1'h1, `RTV_TPTR_WEEKDAY_DIGIT_HOURS, `RTV_APTR_MIN_SEC));
    for (int i = 0; i < 24; i++) begin
      tword = (i == 0) ? tw(3'h6, 2'h2, 4'h9) : tw(3'($urandom % 7), 2'($urandom % 3), 4'($urandom % 10));
      aword = (i == 0) ? aw(3'h5, 4'h9, 3'h5, 4'h9) :
        aw(3'($urandom % 6), 4'($urandom % 10), 3'($urandom % 6), 4'($urandom % 10));
      // unimplemented bits written as ones
      apb(1'h1, `RTV_TIME_OFF, tword | 32'h0000_F8C0);
      apb(1'h1, `RTV_ALARM_OFF, aword | 32'h0000_8080);
      apb(1'h0, `RTV_TIME_OFF, 32'h0);
      check(rd, tword);
      apb(1'h0, `RTV_ALARM_OFF, 32'h0);
      check({rd[30:0], err}, {aword[30:0], 1'h0});
    end
    foreach (bad_t[k]) begin
      apb(1'h1, `RTV_TIME_OFF, bad_t[k]);
      apb(1'h0, `RTV_TIME_OFF, 32'h0);
      check(rd, tword);
    end
    foreach (bad_a[k]) begin
      apb(1'h1, `RTV_ALARM_OFF, bad_a[k]);
      apb(1'h0, `RTV_ALARM_OFF, 32'h0);
      check(rd, aword);
    end
    apb(1'h1, `RTV_CTRL_OFF, cw(1'h0, `RTV_TPTR_WEEKDAY_DIGIT_HOURS, `RTV_APTR_MIN_SEC));
    apb(1'h1, `RTV_TIME_OFF, tword ^ 32'h1);
    apb(1'h0, `RTV_TIME_OFF, 32'h0);
    check(rd, tword);
    apb(1'h0, `RTV_STAT_OFF, 32'h0);
    check(rd & 32'h3, 32'h3);
    apb(1'h1, `RTV_STAT_OFF, 32'h3);
    apb(1'h0, `RTV_STAT_OFF, 32'h0);
    check(rd, 32'h0);
    for (int p = 0; p < 4; p++) begin
      apb(1'h1, `RTV_CTRL_OFF, cw(1'h1, 2'(p), 2'(p)));
      if (p != 1) begin
        apb(1'h1, `RTV_TIME_OFF, tword ^ 32'h1);
      end
      if (p != 0) begin
        apb(1'h1, `RTV_ALARM_OFF, aword ^ 32'h1);
      end
      apb(1'h0, `RTV_TIME_OFF, 32'h0);
      check(rd, (p == 1) ? tword : 32'h0);
      apb(1'h0, `RTV_ALARM_OFF, 32'h0);
      check(rd, (p == 0) ? aword : 32'h0);
    end
    apb(1'h0, 12'h010, 32'h0);
    check({rd[30:0], err}, 32'h1);
    report_and_stop();
  end
endmodule
